//--- hw/tpw_pkg.sv
// Constants for the six-channel buffered PWM timer.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package tpw_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int PRE_W = 6;
    localparam int NUM_CH = 6;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_TCS = 8'h00;
    localparam logic [7:0] OFF_CNT = 8'h04;
    localparam logic [7:0] OFF_MOD = 8'h08;
    localparam logic [7:0] OFF_CH_BASE = 8'h20;
    localparam logic [7:0] CH_STRIDE = 8'h08;
    localparam logic [7:0] CH_CMP_OFF = 8'h04;

    // ------------------------------------------------------------
    // Timer control/status fields
    // ------------------------------------------------------------
    localparam int TCS_FLAG = 7;
    localparam int TCS_IE = 6;
    localparam int TCS_HALT = 5;
    localparam int TCS_RST = 4;
    localparam int TCS_PS_LSB = 0;
    localparam logic [2:0] PS_EXT = 3'h7;

    // ------------------------------------------------------------
    // Channel control/status fields
    // ------------------------------------------------------------
    localparam int CH_FLAG = 7;
    localparam int CH_IE = 6;
    localparam int CH_LINK = 5;
    localparam int CH_MSL = 4;
    localparam int CH_ELS_LSB = 2;
    localparam int CH_TOV = 1;
    localparam int CH_MAX = 0;

    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [15:0] MOD_RST = 16'hffff;
    localparam logic HALT_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Channel operating mode, buffer link bit over low mode bit
    typedef enum logic [1:0] {
        MODE_CAPTURE = 2'h0,
        MODE_UNBUF = 2'h1,
        MODE_BUF = 2'h2
    } tpw_mode_t;

endpackage

//--- hw/tpw_timer.sv
// Six-channel timer with buffered and unbuffered PWM, AXI4-Lite slave.
// Assumes pins arrive asynchronously; mode and break inputs are on aclk.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

module tpw_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [5:0] channel_pin_in,
    output logic [5:0] channel_pin_out,
    output logic [5:0] channel_pin_oe,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_active,
    input wire logic break_flag_clear_enable,
    output logic overflow_irq,
    output logic [5:0] channel_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, w_data_q;
    logic [7:0] aw_addr_q;
    logic [3:0] w_strb_q;
    logic [5:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [15:0] cnt_q, mod_q;
    logic [5:0] pre_q;
    logic [2:0] ps_q;
    logic halt_q, ovf_ie_q, ovf_flag_q, ovf_arm_q, tick_q;
    logic [5:0] ch_flag_q, ch_arm_q, ch_ie_q, ch_link_q, ch_msl_q;
    logic [5:0] ch_tov_q, ch_max_q, out_q, oe_q, ch_irq_q;
    logic [1:0] ch_els_q [6];
    logic [15:0] cmp_q [6];
    logic [2:0] sel_q, last_q;
    logic ovf_irq_q;

    logic bus_ok, clr_ok, run, tick, ovf_evt, wr_fire, rd_fire;
    logic wr_tcs, wr_mod, rd_tcs, cnt_clr;
    logic [5:0] wr_chc, wr_cmp, rd_chc, released, cmp_evt, cap_evt;
    logic [5:0] oc_on, ic_on, rise, fall;
    logic [31:0] wv;
    logic [15:0] eff_cmp [6];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] ctrl_off(input int i);
        return 8'(tpw_pkg::OFF_CH_BASE + 8'(i) * tpw_pkg::CH_STRIDE);
    endfunction

    function automatic logic [7:0] cmp_off(input int i);
        return 8'(ctrl_off(i) + tpw_pkg::CH_CMP_OFF);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        logic hit;
        hit = (a == tpw_pkg::OFF_TCS) || (a == tpw_pkg::OFF_CNT) ||
              (a == tpw_pkg::OFF_MOD);
        for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
            hit = hit || (a == ctrl_off(i)) || (a == cmp_off(i));
        end
        return hit;
    endfunction

    // Buffer link bit takes priority over the low mode bit
    function automatic tpw_pkg::tpw_mode_t eff_mode(input logic link,
                                                    input logic low);
        if (link) begin
            return tpw_pkg::MODE_BUF;
        end
        return low ? tpw_pkg::MODE_UNBUF : tpw_pkg::MODE_CAPTURE;
    endfunction

    function automatic logic [31:0] reg_rd(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        if (a == tpw_pkg::OFF_TCS) begin
            v[tpw_pkg::TCS_FLAG] = ovf_flag_q;
            v[tpw_pkg::TCS_IE] = ovf_ie_q;
            v[tpw_pkg::TCS_HALT] = halt_q;
            v[tpw_pkg::TCS_PS_LSB +: 3] = ps_q;
        end
        if (a == tpw_pkg::OFF_CNT) begin
            v[15:0] = cnt_q;
        end
        if (a == tpw_pkg::OFF_MOD) begin
            v[15:0] = mod_q;
        end
        for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
            if (a == ctrl_off(i) && !released[i]) begin
                v[tpw_pkg::CH_FLAG] = ch_flag_q[i];
                v[tpw_pkg::CH_IE] = ch_ie_q[i];
                v[tpw_pkg::CH_LINK] = ch_link_q[i];
                v[tpw_pkg::CH_MSL] = ch_msl_q[i];
                v[tpw_pkg::CH_ELS_LSB +: 2] = ch_els_q[i];
                v[tpw_pkg::CH_TOV] = ch_tov_q[i];
                v[tpw_pkg::CH_MAX] = ch_max_q[i];
            end
            if (a == cmp_off(i)) begin
                v[15:0] = cmp_q[i];
            end
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Decode and timing strobes
    // ------------------------------------------------------------
    always_comb begin
        bus_ok = !wait_mode;
        clr_ok = !break_active || break_flag_clear_enable;
        run = !halt_q && !break_active && !stop_mode;
        rise = pin_s2_q & ~pin_s3_q;
        fall = ~pin_s2_q & pin_s3_q;
        // Read mux below needs these, so settled first
        for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
            released[i] = (i % 2 == 1) && ch_link_q[i - i % 2];
        end
        wr_fire = !awready_q && !wready_q && !bvalid_q && bus_ok;
        rd_fire = arvalid && arready_q && bus_ok;
        wv = reg_rd(aw_addr_q);
        for (int b = 0; b < 4; b++) begin
            if (w_strb_q[b]) begin
                wv[b*8 +: 8] = w_data_q[b*8 +: 8];
            end
        end
        wr_tcs = wr_fire && aw_addr_q == tpw_pkg::OFF_TCS;
        wr_mod = wr_fire && aw_addr_q == tpw_pkg::OFF_MOD;
        rd_tcs = rd_fire && araddr == tpw_pkg::OFF_TCS;
        cnt_clr = wr_tcs && wv[tpw_pkg::TCS_RST];
        // Counter clock: divided bus clock or synced channel zero pin
        if (ps_q == tpw_pkg::PS_EXT) begin
            tick = run && rise[0];
        end else begin
            tick = run && ((pre_q & 6'((6'h1 << ps_q) - 6'h1)) ==
                           6'((6'h1 << ps_q) - 6'h1));
        end
        ovf_evt = tick_q && cnt_q == mod_q;
        for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
            wr_chc[i] = wr_fire && aw_addr_q == ctrl_off(i);
            wr_cmp[i] = wr_fire && aw_addr_q == cmp_off(i);
            rd_chc[i] = rd_fire && araddr == ctrl_off(i);
            // Even channel of a linked pair uses the selected set
            if (i % 2 == 0 && ch_link_q[i] && sel_q[i/2]) begin
                eff_cmp[i] = cmp_q[i + 1];
            end else begin
                eff_cmp[i] = cmp_q[i];
            end
            oc_on[i] = !released[i] && ch_els_q[i] != tpw_pkg::ELS_OFF &&
                       eff_mode(ch_link_q[i], ch_msl_q[i]) !=
                       tpw_pkg::MODE_CAPTURE;
            ic_on[i] = !released[i] && ch_els_q[i] != tpw_pkg::ELS_OFF &&
                       eff_mode(ch_link_q[i], ch_msl_q[i]) ==
                       tpw_pkg::MODE_CAPTURE;
            cmp_evt[i] = oc_on[i] && tick_q && cnt_q == eff_cmp[i];
            // Captures blocked while halted, in break or in stop
            cap_evt[i] = ic_on[i] && run &&
                         ((ch_els_q[i][0] && rise[i]) ||
                          (ch_els_q[i][1] && fall[i]));
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            aw_addr_q <= 8'h0;
        end else if (awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_addr_q <= awaddr;
        end else if (bvalid_q && bready) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else if (wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (bvalid_q && bready) begin
            wready_q <= 1'b1;
        end
    end

    // Register file unreachable in wait mode: error, no effect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= tpw_pkg::RESP_OKAY;
        end else if (!awready_q && !wready_q && !bvalid_q) begin
            bvalid_q <= 1'b1;
            bresp_q <= (bus_ok && mapped(aw_addr_q)) ?
                       tpw_pkg::RESP_OKAY : tpw_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= tpw_pkg::RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= (bus_ok && mapped(araddr)) ? reg_rd(araddr) : 32'h0;
            rresp_q <= (bus_ok && mapped(araddr)) ?
                       tpw_pkg::RESP_OKAY : tpw_pkg::RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 6'h0;
            pin_s2_q <= 6'h0;
            pin_s3_q <= 6'h0;
        end else begin
            pin_s1_q <= channel_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Timer control, prescaler and counter
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_q <= tpw_pkg::HALT_RST;
            ovf_ie_q <= 1'b0;
            ps_q <= 3'h0;
            mod_q <= tpw_pkg::MOD_RST;
        end else begin
            if (wr_tcs) begin
                halt_q <= wv[tpw_pkg::TCS_HALT];
                ovf_ie_q <= wv[tpw_pkg::TCS_IE];
                ps_q <= wv[tpw_pkg::TCS_PS_LSB +: 3];
            end
            if (wr_mod) begin
                mod_q <= wv[15:0];
            end
        end
    end

    // Frozen in stop and break; contents stay for resume
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= 6'h0;
            cnt_q <= 16'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick && !cnt_clr;
            if (cnt_clr) begin
                pre_q <= 6'h0;
                cnt_q <= 16'h0;
            end else begin
                if (run) begin
                    pre_q <= 6'(pre_q + 6'h1);
                end
                if (tick) begin
                    cnt_q <= (cnt_q == mod_q) ? 16'h0 :
                             16'(cnt_q + 16'h1);
                end
            end
        end
    end

    // Read arms, write of 0 completes; an overflow cancels the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_flag_q <= 1'b0;
            ovf_arm_q <= 1'b0;
        end else if (ovf_evt) begin
            ovf_flag_q <= 1'b1;
            ovf_arm_q <= 1'b0;
        end else if (wr_tcs && clr_ok) begin
            if (ovf_arm_q && !wv[tpw_pkg::TCS_FLAG]) begin
                ovf_flag_q <= 1'b0;
            end
            ovf_arm_q <= 1'b0;
        end else if (rd_tcs && ovf_flag_q && clr_ok) begin
            ovf_arm_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Channel control and flags
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_ie_q <= 6'h0;
            ch_link_q <= 6'h0;
            ch_msl_q <= 6'h0;
            ch_tov_q <= 6'h0;
            ch_max_q <= 6'h0;
            for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
                ch_els_q[i] <= tpw_pkg::ELS_OFF;
            end
        end else begin
            for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
                // Control of a released odd channel ignores writes
                if (wr_chc[i] && !released[i]) begin
                    ch_ie_q[i] <= wv[tpw_pkg::CH_IE];
                    ch_link_q[i] <= (i % 2 == 0) &&
                                    wv[tpw_pkg::CH_LINK];
                    ch_msl_q[i] <= wv[tpw_pkg::CH_MSL];
                    ch_els_q[i] <= wv[tpw_pkg::CH_ELS_LSB +: 2];
                    ch_tov_q[i] <= wv[tpw_pkg::CH_TOV];
                    ch_max_q[i] <= wv[tpw_pkg::CH_MAX];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_flag_q <= 6'h0;
            ch_arm_q <= 6'h0;
        end else begin
            for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
                if (cmp_evt[i] || cap_evt[i]) begin
                    ch_flag_q[i] <= 1'b1;
                    ch_arm_q[i] <= 1'b0;
                end else if (wr_chc[i] && clr_ok) begin
                    if (ch_arm_q[i] && !wv[tpw_pkg::CH_FLAG]) begin
                        ch_flag_q[i] <= 1'b0;
                    end
                    ch_arm_q[i] <= 1'b0;
                end else if (rd_chc[i] && ch_flag_q[i] && clr_ok) begin
                    ch_arm_q[i] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Compare registers and buffered pair selection
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
                cmp_q[i] <= 16'h0;
            end
        end else begin
            for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
                if (cap_evt[i]) begin
                    cmp_q[i] <= cnt_q;
                end else if (wr_cmp[i]) begin
                    cmp_q[i] <= wv[15:0];
                end
            end
        end
    end

    // Switching only at overflow keeps each pulse on one value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= 3'h0;
            last_q <= 3'h0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (!ch_link_q[2*p]) begin
                    sel_q[p] <= 1'b0;
                    last_q[p] <= 1'b0;
                end else begin
                    if (wr_cmp[2*p+1]) begin
                        last_q[p] <= 1'b1;
                    end else if (wr_cmp[2*p]) begin
                        last_q[p] <= 1'b0;
                    end
                    if (ovf_evt) begin
                        sel_q[p] <= last_q[p];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Channel outputs and interrupt requests
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_q <= 6'h0;
            oe_q <= 6'h0;
        end else begin
            for (int i = 0; i < tpw_pkg::NUM_CH; i++) begin
                oe_q[i] <= oc_on[i];
                if (oc_on[i] && ch_max_q[i] && ch_tov_q[i] &&
                    ch_els_q[i] != tpw_pkg::ELS_TOGGLE) begin
                    out_q[i] <= ch_els_q[i] == tpw_pkg::ELS_CLEAR;
                end else if (oc_on[i]) begin
                    // Compare after toggle: equal values end at compare
                    if (cmp_evt[i]) begin
                        unique case (ch_els_q[i])
                            tpw_pkg::ELS_CLEAR: out_q[i] <= 1'b0;
                            tpw_pkg::ELS_SET: out_q[i] <= 1'b1;
                            default: out_q[i] <= !(out_q[i] ^
                                (ovf_evt && ch_tov_q[i]));
                        endcase
                    end else if (ovf_evt && ch_tov_q[i]) begin
                        out_q[i] <= !out_q[i];
                    end
                end
            end
        end
    end

    // Any enabled request also serves as the wake from wait mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_irq_q <= 1'b0;
            ch_irq_q <= 6'h0;
        end else begin
            ovf_irq_q <= ovf_flag_q && ovf_ie_q;
            ch_irq_q <= ch_flag_q & ch_ie_q & ~released;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign channel_pin_out = out_q;
    assign channel_pin_oe = oe_q;
    assign overflow_irq = ovf_irq_q;
    assign channel_irq = ch_irq_q;

endmodule

//--- tb/testbench.sv
// Self-checking bench for the PWM timer.
// Assumes tpw_timer, tpw_load and the checker are compiled.
`timescale 1ns/1ps
module testbench;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, wait_mode = 0, stop_mode = 0;
    logic break_active = 0, awready, wready, bvalid, arready, rvalid;
    logic overflow_irq, bfce = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [5:0] pout, poe, plvl, ext = 0, channel_irq;
    int mismatches = 0, num_checks = 0, hc[6], cmp;
    always #12.5 aclk = ~aclk;
    tpw_timer dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .channel_pin_in(plvl), .channel_pin_out(pout),
        .channel_pin_oe(poe), .wait_mode, .stop_mode, .break_active,
        .break_flag_clear_enable(bfce), .overflow_irq, .channel_irq);
    tpw_load u_load (.drv(pout), .oe(poe), .ext, .lvl(plvl));
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        r = bresp;
        bready <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        d = rdata; r = rresp; rready <= 0;
    endtask
    // Window of 100 is a whole number of 10-cycle periods
    task meas;
        hc = '{default: 0};
        repeat (100) begin
            @(posedge aclk);
            foreach (hc[i]) hc[i] += int'(pout[i]);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        mismatches++;
        complete_run;
    end
    initial begin
        void'($urandom(32'h5fe3));
        cmp = $urandom_range(1, 8);
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd(8'h08); chk(d, 32'hffff);
        rd(8'h00); chk(d, 32'h20);
        rd(8'h10); chk(32'(r), 32'h2);
        wr(8'h00, 32'h30);
        chk(32'(r), 32'h0);
        wr(8'h08, 32'h9);
        wr(8'h24, 32'(cmp));
        wr(8'h34, 32'h2);
        wr(8'h20, 32'h1a);
        wr(8'h30, 32'h3a);
        wr(8'h38, 32'h1a);
        wr(8'h40, 32'h1b);
        wr(8'h48, 32'h18);
        wr(8'h00, 32'h40);
        repeat (30) @(posedge aclk);
        meas;
        chk(32'(hc[0]), 32'(10 * (cmp + 1)));
        chk(32'(hc[2]), 32'd30);
        chk(32'(hc[4]), 32'd100);
        chk(32'(hc[5]), 32'd0);
        chk(32'(poe[3]), 32'h0);
        rd(8'h38);
        chk(d, 32'h0);
        chk(32'(channel_irq), 32'h0);
        wr(8'h20, 32'h5a);
        rd(8'h20);
        chk(d, 32'hda);
        chk(32'(channel_irq), 32'h1);
        ext <= 6'($urandom);
        wr(8'h3c, 32'h6);
        repeat (30) @(posedge aclk);
        meas;
        chk(32'(hc[2]), 32'd70);
        stop_mode <= 1;
        repeat (20) @(posedge aclk);
        stop_mode <= 0; break_active <= 1;
        repeat (20) @(posedge aclk);
        break_active <= 0;
        wr(8'h00, 32'h60);
        rd(8'h00); chk(d, 32'he0);
        chk(32'(overflow_irq), 32'h1);
        break_active <= 1;
        wr(8'h00, 32'h60);
        rd(8'h00); chk(d, 32'he0);
        break_active <= 0;
        wr(8'h00, 32'h60);
        rd(8'h00); chk(d, 32'h60);
        wait_mode <= 1;
        rd(8'h00); chk(32'(r), 32'h2);
        wr(8'h08, 32'h3);
        chk(32'(r), 32'h2);
        wait_mode <= 0;
        rd(8'h08);
        chk(d, 32'h9);
        wr(8'h00, 32'h40);
        repeat (12) @(posedge aclk);
        break_active <= 1;
        bfce <= 1;
        rd(8'h00);
        chk(d, 32'hc0);
        wr(8'h00, 32'h60);
        break_active <= 0;
        bfce <= 0;
        rd(8'h00);
        chk(d, 32'h60);
        chk(32'(overflow_irq), 32'h0);
        complete_run;
    end
endmodule

//--- tb/tpw_load.sv
// Loads and outside drivers on the six channel pins.
// Assumes ext is what outside parts drive on free pins.
`timescale 1ns/1ps
module tpw_load (
    input wire logic [5:0] drv,
    input wire logic [5:0] oe,
    input wire logic [5:0] ext,
    output logic [5:0] lvl
);
    // Timer wins where it drives, else the outside part
    assign lvl = (drv & oe) | (ext & ~oe);
endmodule

//--- tb/tpw_props.sv
// Checker for the timer bus and pin ports.
// Assumes it is bound onto tpw_timer.
`timescale 1ns/1ps
module tpw_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [5:0] channel_pin_out,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_active
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold; bvalid && !bready |=> bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("b dropped");
    property p_r_hold; rvalid && !rready |=> rvalid; endproperty
    a_r_hold: assert property (p_r_hold) else $error("r dropped");
    property p_b_time;
        awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
    endproperty
    a_b_time: assert property (p_b_time) else $error("b late");
    property p_r_time; arvalid && arready |=> rvalid && !arready; endproperty
    a_r_time: assert property (p_r_time) else $error("r late");
    property p_b_busy; bvalid |-> !awready && !wready; endproperty
    a_b_busy: assert property (p_b_busy) else $error("ready in b");
    property p_r_wait;
        $rose(rvalid) && wait_mode && $past(wait_mode) |-> rresp == 2'h2;
    endproperty
    a_r_wait: assert property (p_r_wait) else $error("wait read");
    // Guarded by awready so register writes may still move pins
    property p_stop;
        (stop_mode && awready)[*4] |=> $stable(channel_pin_out);
    endproperty
    a_stop: assert property (p_stop) else $error("stop moved");
    property p_brk;
        (break_active && awready)[*4] |=> $stable(channel_pin_out);
    endproperty
    a_brk: assert property (p_brk) else $error("break moved");
endmodule
bind tpw_timer tpw_props u_props (.*);
